// file: core/exec_pkg.sv
// Behaviour
// RULE1: Add two registers, optionally with carry; write sum, set Z C N V H; one cycle.
// RULE2: Word add of constant to register pair, high byte upper; set Z C N V S; two cycles.
// RULE3: Word subtract of constant from register pair; set Z C N V S; two cycles.
// RULE4: Subtract register or constant, optionally with borrow; write; set Z C N V H; one cycle.
// RULE5: AND, OR, XOR with register or constant; write; set only Z N V; one cycle; code also sets S.
// RULE6: Set mask ORs constant in, clear mask ANDs inverted constant; Z N V; one cycle.
// RULE7: Test ANDs register with itself, value unchanged; Z N V; one cycle.
// RULE8: Compares compute difference without writing; set Z N V C H; one cycle.
// RULE9: Relative call loads PC plus offset plus one, saves return; three cycles; no flags.
// RULE10: Pointer jump loads PC from Z pair in two cycles; flags unchanged.
// RULE11: Pointer call loads PC from Z pair, pushes return address; three cycles; no flags.
// RULE12: Compare-skip skips next instruction when registers equal; one to three cycles; no flags.
// RULE13: Register bit skips skip when selected bit matches tested level; one to three cycles.
// RULE14: I/O bit skips skip when selected I/O bit matches tested level; one to three cycles.
// RULE15: Flag branches test indexed status bit, set or clear, add offset plus one.
// RULE16: Signed branches use N xor V: ge taken on zero, lt taken on one.
// RULE17: Unsigned branches use carry: ge taken on zero, lt taken on one.
// RULE18: Branches on I, H, T, V flags taken on one, or zero for cleared forms.
// RULE19: Branch takes one cycle untaken, two taken; skip adds one cycle per word.
`default_nettype none
package exec_pkg;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam int MSB_BYTE = 7;
    localparam int MSB_WORD = 15;
    localparam int HALF_BIT = 4;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [15:0] PC_STEP_ONE = 16'h0001;
    localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
    localparam logic [15:0] PC_SKIP_LONG = 16'h0003;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RESULT = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;

    typedef enum logic [25:0] {
        OP_ADD = 26'h0000001,
        OP_ADD_CARRY = 26'h0000002,
        OP_SUB = 26'h0000004,
        OP_SUB_BORROW = 26'h0000008,
        OP_COMPARE = 26'h0000010,
        OP_COMPARE_CARRY = 26'h0000020,
        OP_WORD_ADD = 26'h0000040,
        OP_WORD_SUB = 26'h0000080,
        OP_AND = 26'h0000100,
        OP_OR = 26'h0000200,
        OP_XOR = 26'h0000400,
        OP_CLEAR_MASK = 26'h0000800,
        OP_ZERO_MINUS_TEST = 26'h0001000,
        OP_COMPARE_SKIP = 26'h0002000,
        OP_SKIP_REG_CLR = 26'h0004000,
        OP_SKIP_REG_SET = 26'h0008000,
        OP_SKIP_IO_CLR = 26'h0010000,
        OP_SKIP_IO_SET = 26'h0020000,
        OP_BRANCH_SET = 26'h0040000,
        OP_BRANCH_CLR = 26'h0080000,
        OP_BRANCH_SGE = 26'h0100000,
        OP_BRANCH_SLT = 26'h0200000,
        OP_REL_JUMP = 26'h0400000,
        OP_PTR_JUMP = 26'h0800000,
        OP_REL_CALL = 26'h1000000,
        OP_PTR_CALL = 26'h2000000
    } exec_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } exec_state_t;

    typedef struct packed {
        exec_op_t op;
        logic use_imm;
        logic [7:0] rd;
        logic [7:0] rd_hi;
        logic [7:0] rr;
        logic [7:0] imm;
        logic [11:0] offset;
        logic [2:0] bit_sel;
        logic [7:0] io_val;
        logic [15:0] pc;
        logic [15:0] zptr;
        logic next_two_word;
    } exec_req_t;

    typedef struct packed {
        logic wr_en;
        logic wr_pair;
        logic [15:0] wr_data;
        logic pc_load;
        logic [15:0] pc_value;
        logic push_en;
        logic [15:0] push_addr;
    } exec_rsp_t;
endpackage
`default_nettype wire

// file: core/alu_branch_exec.sv
`default_nettype none
module alu_branch_exec import exec_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire exec_req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output exec_rsp_t rsp_o,
    output logic [7:0] status_flags_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    exec_state_t state;
    logic [1:0] wait_cnt;
    logic [15:0] last_result;
    logic [15:0] done_count;
    logic [7:0] next_flags;
    exec_rsp_t next_rsp;
    logic [1:0] next_cycles;
    logic [31:0] next_rdata;

    wire accept = req_valid_i & req_ready_o;
    wire [7:0] flags = status_flags_o;
    wire with_carry = (req_i.op == OP_ADD_CARRY) | (req_i.op == OP_SUB_BORROW)
                    | (req_i.op == OP_COMPARE_CARRY);
    wire carry_in = with_carry & flags[FLAG_C];
    wire [7:0] op_a = req_i.rd;
    wire [7:0] op_b = req_i.use_imm ? req_i.imm : req_i.rr;

    wire [8:0] add_sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};
    wire [4:0] add_half = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
    wire add_ovf = (op_a[MSB_BYTE] & op_b[MSB_BYTE] & ~add_sum[MSB_BYTE])
                 | (~op_a[MSB_BYTE] & ~op_b[MSB_BYTE] & add_sum[MSB_BYTE]);
    wire [8:0] sub_diff = {1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_in};
    wire [4:0] sub_half = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in};
    wire sub_ovf = (op_a[MSB_BYTE] & ~op_b[MSB_BYTE] & ~sub_diff[MSB_BYTE])
                 | (~op_a[MSB_BYTE] & op_b[MSB_BYTE] & sub_diff[MSB_BYTE]);

    wire [15:0] word_pair = {req_i.rd_hi, req_i.rd};
    wire [15:0] word_k = {10'h000, req_i.imm[5:0]};
    wire [15:0] word_add = word_pair + word_k;
    wire [15:0] word_sub = word_pair - word_k;

    wire [15:0] branch_target = req_i.pc + {{4{req_i.offset[11]}}, req_i.offset} + PC_STEP_ONE;
    wire [15:0] return_addr = req_i.pc + PC_STEP_ONE;
    wire [15:0] skip_target = req_i.pc + (req_i.next_two_word ? PC_SKIP_LONG : PC_SKIP_SHORT);
    wire [1:0] skip_cycles = req_i.next_two_word ? CYC_THREE : CYC_TWO;
    wire flag_sel = flags[req_i.bit_sel];
    wire signed_lt = flags[FLAG_N] ^ flags[FLAG_V];

    wire apb_setup = psel_i & ~penable_i;
    wire apb_write = psel_i & penable_i & pwrite_i & pready_o;
    wire addr_status = paddr_i == ADDR_STATUS;
    wire addr_result = paddr_i == ADDR_RESULT;
    wire addr_count = paddr_i == ADDR_COUNT;
    wire addr_mapped = addr_status | addr_result | addr_count;
    wire status_wr = apb_write & addr_status & pstrb_i[0];

    // Flag update shared by byte add and subtract: Z may chain from the previous Z.
    function automatic logic [7:0] arith_flags(input logic [7:0] f, input logic [7:0] r,
                                               input logic c, input logic v, input logic h,
                                               input logic z_chain);
        logic [7:0] o;
        o = f;
        o[FLAG_C] = c;
        o[FLAG_Z] = (r == 8'h00) & (~z_chain | f[FLAG_Z]);
        o[FLAG_N] = r[MSB_BYTE];
        o[FLAG_V] = v;
        o[FLAG_S] = r[MSB_BYTE] ^ v;
        o[FLAG_H] = h;
        return o;
    endfunction

    function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[FLAG_Z] = r == 8'h00;
        o[FLAG_N] = r[MSB_BYTE];
        o[FLAG_V] = 1'b0;
        o[FLAG_S] = r[MSB_BYTE];
        return o;
    endfunction

    function automatic logic [7:0] word_flags(input logic [7:0] f, input logic [15:0] r,
                                              input logic c, input logic v);
        logic [7:0] o;
        o = f;
        o[FLAG_C] = c;
        o[FLAG_Z] = r == 16'h0000;
        o[FLAG_N] = r[MSB_WORD];
        o[FLAG_V] = v;
        o[FLAG_S] = r[MSB_WORD] ^ v;
        return o;
    endfunction

    always_comb begin
        next_flags = flags;
        next_rsp = '0;
        next_rsp.pc_value = req_i.pc;
        next_cycles = CYC_ONE;
        unique case (req_i.op)
            OP_ADD, OP_ADD_CARRY: begin
                next_rsp.wr_en = 1'b1; // RULE1
                next_rsp.wr_data = {8'h00, add_sum[7:0]};
                next_flags = arith_flags(flags, add_sum[7:0], add_sum[8], add_ovf,
                                         add_half[HALF_BIT], 1'b0);
            end
            OP_SUB, OP_SUB_BORROW: begin
                next_rsp.wr_en = 1'b1; // RULE4
                next_rsp.wr_data = {8'h00, sub_diff[7:0]};
                next_flags = arith_flags(flags, sub_diff[7:0], sub_diff[8], sub_ovf,
                                         sub_half[HALF_BIT], with_carry);
            end
            OP_COMPARE, OP_COMPARE_CARRY: begin
                // The difference only shapes the flags; nothing is written back.
                next_flags = arith_flags(flags, sub_diff[7:0], sub_diff[8], sub_ovf,
                                         sub_half[HALF_BIT], with_carry); // RULE8
            end
            OP_WORD_ADD: begin
                next_rsp.wr_en = 1'b1; // RULE2
                next_rsp.wr_pair = 1'b1;
                next_rsp.wr_data = word_add;
                next_cycles = CYC_TWO;
                next_flags = word_flags(flags, word_add,
                                        ~word_add[MSB_WORD] & req_i.rd_hi[MSB_BYTE],
                                        ~req_i.rd_hi[MSB_BYTE] & word_add[MSB_WORD]);
            end
            OP_WORD_SUB: begin
                next_rsp.wr_en = 1'b1; // RULE3
                next_rsp.wr_pair = 1'b1;
                next_rsp.wr_data = word_sub;
                next_cycles = CYC_TWO;
                next_flags = word_flags(flags, word_sub,
                                        word_sub[MSB_WORD] & ~req_i.rd_hi[MSB_BYTE],
                                        req_i.rd_hi[MSB_BYTE] & ~word_sub[MSB_WORD]);
            end
            OP_AND: begin
                next_rsp.wr_en = 1'b1; // RULE5
                next_rsp.wr_data = {8'h00, op_a & op_b};
                next_flags = logic_flags(flags, op_a & op_b);
            end
            OP_OR: begin
                // Setting mask bits is the constant form of this operation.
                next_rsp.wr_en = 1'b1; // RULE5 RULE6
                next_rsp.wr_data = {8'h00, op_a | op_b};
                next_flags = logic_flags(flags, op_a | op_b);
            end
            OP_XOR: begin
                next_rsp.wr_en = 1'b1; // RULE5
                next_rsp.wr_data = {8'h00, op_a ^ op_b};
                next_flags = logic_flags(flags, op_a ^ op_b);
            end
            OP_CLEAR_MASK: begin
                next_rsp.wr_en = 1'b1; // RULE6
                next_rsp.wr_data = {8'h00, op_a & ~req_i.imm};
                next_flags = logic_flags(flags, op_a & ~req_i.imm);
            end
            OP_ZERO_MINUS_TEST: begin
                next_rsp.wr_en = 1'b1; // RULE7
                next_rsp.wr_data = {8'h00, op_a & op_a};
                next_flags = logic_flags(flags, op_a & op_a);
            end
            OP_COMPARE_SKIP: begin
                next_rsp.pc_load = req_i.rd == req_i.rr; // RULE12
                next_rsp.pc_value = skip_target;
                next_cycles = next_rsp.pc_load ? skip_cycles : CYC_ONE; // RULE19
            end
            OP_SKIP_REG_CLR, OP_SKIP_REG_SET: begin
                next_rsp.pc_load = req_i.rr[req_i.bit_sel]
                                   == (req_i.op == OP_SKIP_REG_SET); // RULE13
                next_rsp.pc_value = skip_target;
                next_cycles = next_rsp.pc_load ? skip_cycles : CYC_ONE;
            end
            OP_SKIP_IO_CLR, OP_SKIP_IO_SET: begin
                next_rsp.pc_load = req_i.io_val[req_i.bit_sel]
                                   == (req_i.op == OP_SKIP_IO_SET); // RULE14
                next_rsp.pc_value = skip_target;
                next_cycles = next_rsp.pc_load ? skip_cycles : CYC_ONE;
            end
            OP_BRANCH_SET, OP_BRANCH_CLR: begin
                // Carry, interrupt, half-carry, transfer and overflow forms arrive here
                // with the flag's index in bit_sel.
                next_rsp.pc_load = flag_sel == (req_i.op == OP_BRANCH_SET); // RULE15 RULE17 RULE18
                next_rsp.pc_value = branch_target;
                next_cycles = next_rsp.pc_load ? CYC_TWO : CYC_ONE; // RULE19
            end
            OP_BRANCH_SGE, OP_BRANCH_SLT: begin
                next_rsp.pc_load = signed_lt == (req_i.op == OP_BRANCH_SLT); // RULE16
                next_rsp.pc_value = branch_target;
                next_cycles = next_rsp.pc_load ? CYC_TWO : CYC_ONE;
            end
            OP_REL_JUMP: begin
                next_rsp.pc_load = 1'b1;
                next_rsp.pc_value = branch_target;
                next_cycles = CYC_TWO;
            end
            OP_PTR_JUMP: begin
                next_rsp.pc_load = 1'b1; // RULE10
                next_rsp.pc_value = req_i.zptr;
                next_cycles = CYC_TWO;
            end
            OP_REL_CALL, OP_PTR_CALL: begin
                next_rsp.pc_load = 1'b1; // RULE9 RULE11
                next_rsp.pc_value = (req_i.op == OP_REL_CALL) ? branch_target : req_i.zptr;
                next_rsp.push_en = 1'b1;
                next_rsp.push_addr = return_addr;
                next_cycles = CYC_THREE;
            end
            default: begin
                next_flags = flags;
            end
        endcase
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (addr_status) begin
            next_rdata = {24'h000000, flags};
        end else if (addr_result) begin
            next_rdata = {16'h0000, last_result};
        end else if (addr_count) begin
            next_rdata = {16'h0000, done_count};
        end
    end

    // Multi-cycle work holds ready low so the decoder cannot issue early.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            wait_cnt <= 2'h0;
            req_ready_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    done_o <= accept & (next_cycles == CYC_ONE);
                    if (accept && next_cycles != CYC_ONE) begin
                        state <= ST_BUSY;
                        req_ready_o <= 1'b0;
                        wait_cnt <= next_cycles - CYC_TWO;
                    end
                end
                ST_BUSY: begin
                    done_o <= wait_cnt == 2'h0;
                    if (wait_cnt == 2'h0) begin
                        state <= ST_IDLE;
                        req_ready_o <= 1'b1;
                    end else begin
                        wait_cnt <= wait_cnt - 2'h1;
                    end
                end
            endcase
        end
    end

    // An instruction's flag update beats a software write in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_flags_o <= FLAGS_RESET;
        end else if (accept) begin
            status_flags_o <= next_flags;
        end else if (status_wr) begin
            status_flags_o <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
            last_result <= 16'h0000;
        end else if (accept) begin
            rsp_o <= next_rsp;
            last_result <= next_rsp.wr_en ? next_rsp.wr_data : last_result;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_count <= 16'h0000;
        end else if (done_o) begin
            done_count <= done_count + 16'h0001;
        end
    end

    // No wait state: data and error are latched in setup, pready rises for the access.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
            if (apb_setup) begin
                prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
                pslverr_o <= ~addr_mapped;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_add_one_cycle: assert property (accept && req_i.op == OP_ADD && !req_i.use_imm // RULE1
        |=> done_o && rsp_o.wr_en && rsp_o.wr_data[7:0] == 8'($past(req_i.rd) + $past(req_i.rr)))
        else $error("byte add result or timing wrong");
    a_word_add_time: assert property (accept && req_i.op == OP_WORD_ADD // RULE2
        |=> !done_o && !req_ready_o ##1 done_o && rsp_o.wr_pair)
        else $error("word add did not take two cycles");
    a_word_sub_value: assert property (accept && req_i.op == OP_WORD_SUB // RULE3
        |=> ##1 done_o && rsp_o.wr_data == $past(word_pair, 2) - $past(word_k, 2))
        else $error("word subtract result wrong");
    a_sub_borrow_flag: assert property (accept && req_i.op == OP_SUB && op_a < op_b // RULE4
        |=> status_flags_o[FLAG_C] && done_o)
        else $error("subtract borrow not flagged");
    a_logic_clears_v: assert property (accept && (req_i.op == OP_AND || req_i.op == OP_XOR) // RULE5
        |=> !status_flags_o[FLAG_V] && $stable(status_flags_o[FLAG_C]))
        else $error("logic op touched V or C");
    a_compare_no_write: assert property (accept && req_i.op == OP_COMPARE // RULE8
        |=> done_o && !rsp_o.wr_en && !rsp_o.pc_load)
        else $error("compare wrote a register");
    a_call_three_cycles: assert property (accept && req_i.op == OP_PTR_CALL // RULE11
        |=> !done_o [*2] ##1 done_o && rsp_o.push_en && $stable(status_flags_o))
        else $error("pointer call timing wrong");
    a_jump_target: assert property (accept && req_i.op == OP_PTR_JUMP // RULE10
        |=> ##1 done_o && rsp_o.pc_value == $past(req_i.zptr, 2))
        else $error("pointer jump target wrong");
    a_skip_short: assert property (accept && req_i.op == OP_COMPARE_SKIP // RULE12
        && req_i.rd == req_i.rr && !req_i.next_two_word
        |=> !done_o ##1 done_o && rsp_o.pc_load && $stable(status_flags_o))
        else $error("equal compare did not skip in two cycles");
    a_branch_untaken: assert property (accept && req_i.op == OP_BRANCH_SET && !flag_sel // RULE19
        |=> done_o && !rsp_o.pc_load)
        else $error("untaken branch not one cycle");
    a_signed_lt: assert property (accept && req_i.op == OP_BRANCH_SLT && signed_lt // RULE16
        |=> !done_o ##1 done_o && rsp_o.pc_load)
        else $error("signed less-than branch not taken");
endmodule
`default_nettype wire

// file: sim/exec_decoder_model.sv
`default_nettype none
module exec_decoder_model import exec_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic issue_i,
    input wire exec_req_t instr_i,
    input wire logic req_ready_i,
    output logic req_valid_o,
    output exec_req_t req_o
);
    // An offer is held until taken; afterwards the lines carry inverted junk, not stale data.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_valid_o <= 1'h0;
            req_o <= '0;
        end else if (req_valid_o && req_ready_i) begin
            req_valid_o <= 1'h0;
            req_o <= exec_req_t'(~req_o);
        end else if (issue_i) begin
            req_valid_o <= 1'h1;
            req_o <= instr_i;
        end
    end
endmodule
`default_nettype wire

// file: sim/cpu_alu_branch_exec_test.sv
`default_nettype none
module cpu_alu_branch_exec_test import exec_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        exec_op_t op;
        logic imm;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] fin;
        logic wr;
        logic [15:0] res;
        logic [7:0] fl;
        logic [1:0] cyc;
    } row_t;
    row_t rows [16] = '{
        '{OP_ADD, 1'h0, 8'h0f, 8'h01, 8'h00, 1'h1, 16'h0010, 8'h20, 2'h1},
        '{OP_ADD, 1'h0, 8'h80, 8'h80, 8'h00, 1'h1, 16'h0000, 8'h1b, 2'h1},
        '{OP_ADD_CARRY, 1'h0, 8'h7f, 8'h00, 8'h01, 1'h1, 16'h0080, 8'h2c, 2'h1},
        '{OP_SUB, 1'h0, 8'h10, 8'h01, 8'hc0, 1'h1, 16'h000f, 8'he0, 2'h1},
        '{OP_SUB, 1'h1, 8'h00, 8'h01, 8'h00, 1'h1, 16'h00ff, 8'h35, 2'h1},
        '{OP_SUB_BORROW, 1'h0, 8'h01, 8'h01, 8'h02, 1'h1, 16'h0000, 8'h02, 2'h1},
        '{OP_AND, 1'h0, 8'hf0, 8'h0f, 8'h29, 1'h1, 16'h0000, 8'h23, 2'h1},
        '{OP_OR, 1'h1, 8'h01, 8'h80, 8'h00, 1'h1, 16'h0081, 8'h14, 2'h1},
        '{OP_XOR, 1'h0, 8'hff, 8'hff, 8'h00, 1'h1, 16'h0000, 8'h02, 2'h1},
        '{OP_CLEAR_MASK, 1'h1, 8'hff, 8'h0f, 8'h00, 1'h1, 16'h00f0, 8'h14, 2'h1},
        '{OP_ZERO_MINUS_TEST, 1'h0, 8'h00, 8'h00, 8'h00, 1'h1, 16'h0000, 8'h02, 2'h1},
        '{OP_COMPARE, 1'h0, 8'h05, 8'h05, 8'h00, 1'h0, 16'h0000, 8'h02, 2'h1},
        '{OP_COMPARE, 1'h1, 8'h00, 8'h01, 8'h00, 1'h0, 16'h0000, 8'h35, 2'h1},
        '{OP_COMPARE_CARRY, 1'h0, 8'h05, 8'h04, 8'h03, 1'h0, 16'h0000, 8'h02, 2'h1},
        '{OP_WORD_ADD, 1'h1, 8'hff, 8'h01, 8'h20, 1'h1, 16'h0100, 8'h20, 2'h2},
        '{OP_WORD_SUB, 1'h1, 8'h00, 8'h01, 8'h20, 1'h1, 16'hffff, 8'h35, 2'h2}};
    exec_op_t fop [10] = '{OP_COMPARE_SKIP, OP_COMPARE_SKIP, OP_SKIP_REG_SET, OP_SKIP_REG_CLR,
        OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_PTR_JUMP, OP_PTR_CALL, OP_REL_CALL, OP_REL_JUMP};
    logic [9:0] ftw = 10'h011;
    int fcy [10] = '{3, 2, 2, 1, 3, 1, 2, 3, 3, 2};
    logic [15:0] fpc [10] = '{16'h0103, 16'h0102, 16'h0102, 16'h0000, 16'h0103, 16'h0000,
        16'h1234, 16'h1234, 16'hf901, 16'hf901};
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic issue = 1'h0;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'h0;
    exec_req_t q = '0;
    exec_req_t instr = '0;
    exec_req_t req_i;
    exec_rsp_t rsp_o;
    logic req_valid_i, req_ready_o, done_o, pready_o, pslverr_o, rerr;
    logic [7:0] status_flags_o;
    logic [31:0] prdata_o, rdat;
    int n_fail = 0;
    int n_compared = 0;
    int n_done = 0;
    int kc, i, j;

    always #5 clk_i = ~clk_i;

    exec_decoder_model exec_decoder_model_inst (.clk_i, .rst_i, .issue_i(issue), .instr_i(instr),
        .req_ready_i(req_ready_o), .req_valid_o(req_valid_i), .req_o(req_i));
    alu_branch_exec alu_branch_exec_inst (.clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o,
        .done_o, .rsp_o, .status_flags_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i, .prdata_o, .pready_o, .pslverr_o);

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Cycles are counted from the taking edge, so a one-cycle op reads 1.
    task automatic run(input exec_req_t r);
        int k;
        @(posedge clk_i);
        issue <= 1'h1;
        instr <= r;
        @(posedge clk_i);
        issue <= 1'h0;
        for (k = 1; k < 9; k++) begin
            @(posedge clk_i);
            #1;
            if (done_o === 1'h1) break;
        end
        kc = k;
        n_done++;
        if (k == 9) begin
            n_fail++;
            test_done();
        end
    endtask

    // Ready is sampled at the rising edge; read data is taken and the request dropped there.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'h1;
        for (k = 0; k < 9; k++) begin
            @(posedge clk_i);
            if (pready_o === 1'h1) break;
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        if (k == 9) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic flow(input int c, input logic ld, input logic [15:0] p);
        chk(kc, c);
        chk(rsp_o.pc_load, ld);
        if (ld) chk(rsp_o.pc_value, p);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        chk({req_ready_o, done_o, pready_o, status_flags_o}, {3'h4, FLAGS_RESET});
        for (i = 0; i < 16; i++) begin
            apb(1'h1, ADDR_STATUS, {24'h0, rows[i].fin}, 4'hf);
            q.op = rows[i].op;
            q.use_imm = rows[i].imm;
            q.rd = rows[i].rd;
            q.rr = rows[i].rr;
            q.imm = rows[i].rr;
            run(q);
            chk(kc, rows[i].cyc);
            chk(rsp_o.wr_en, rows[i].wr);
            if (rows[i].wr) chk(rsp_o.wr_pair ? rsp_o.wr_data : {8'h00, rsp_o.wr_data[7:0]},
                rows[i].res);
            chk(status_flags_o, rows[i].fl);
            $display("row %0d done", i);
        end
        apb(1'h0, ADDR_RESULT, 32'h0, 4'h0);
        chk(rdat, 32'h0000ffff);
        apb(1'h1, ADDR_STATUS, 32'h0, 4'h0);
        apb(1'h0, ADDR_STATUS, 32'h0, 4'h0);
        chk(rdat, 32'h35);
        chk(rerr, 1'h0);
        apb(1'h0, ADDR_COUNT, 32'h0, 4'h0);
        chk(rdat, n_done);
        apb(1'h0, 8'h0c, 32'h0, 4'h0);
        chk(rerr, 1'h1);
        $display("register access test done");
        q = '0;
        q.pc = 16'h0100;
        q.offset = 12'hffe;
        for (i = 0; i < 8; i++) begin
            apb(1'h1, ADDR_STATUS, 32'h1 << i, 4'hf);
            for (j = 0; j < 4; j++) begin
                q.op = j[1] ? OP_BRANCH_CLR : OP_BRANCH_SET;
                q.bit_sel = i[2:0] + {2'h0, j[0]};
                run(q);
                flow(j[0] == j[1] ? 2 : 1, j[0] == j[1], 16'h00ff);
            end
            chk(status_flags_o, 32'h1 << i);
        end
        for (j = 0; j < 2; j++) begin
            apb(1'h1, ADDR_STATUS, j ? 32'hc : 32'h4, 4'hf);
            q.op = OP_BRANCH_SGE;
            run(q);
            flow(j ? 2 : 1, j == 1, 16'h00ff);
            q.op = OP_BRANCH_SLT;
            run(q);
            flow(j ? 1 : 2, j == 0, 16'h00ff);
        end
        $display("branch test done");
        apb(1'h1, ADDR_STATUS, 32'h5a, 4'hf);
        q.rd = 8'h08;
        q.rr = 8'h08;
        q.bit_sel = 3'h3;
        q.zptr = 16'h1234;
        q.offset = 12'h800;
        for (i = 0; i < 10; i++) begin
            q.op = fop[i];
            q.next_two_word = ftw[i];
            run(q);
            flow(fcy[i], fpc[i] != 16'h0, fpc[i]);
            if (i == 7 || i == 8) chk({rsp_o.push_en, rsp_o.push_addr}, 17'h10101);
        end
        chk(status_flags_o, 8'h5a);
        $display("skip and call test done");
        // Reset lands while a three-cycle call holds ready low.
        q.op = OP_PTR_CALL;
        @(posedge clk_i);
        issue <= 1'h1;
        instr <= q;
        repeat (2) @(posedge clk_i);
        issue <= 1'h0;
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        chk({req_ready_o, done_o, pready_o, status_flags_o}, {3'h4, FLAGS_RESET});
        chk(rsp_o.pc_load, 1'h0);
        apb(1'h0, ADDR_COUNT, 32'h0, 4'h0);
        chk(rdat, 32'h0);
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire
